/* design/rbo_core.sv */
`timescale 1ns/10ps
`default_nettype none

module rbo_core #(
	parameter int LOCK_COUNT = rbo_pkg::LOCK_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clock_input_i,
	input wire logic master_reset_n_i,
	input wire logic [3:0] mode_pins_i,
	input wire logic bus_request_i,
	input wire logic byte_dma_word_done_i,
	input wire logic host_pm0_write_i,
	input wire logic host_ack_i,
	input wire logic pm_access_i,
	input wire logic [13:0] pm_addr_i,
	input wire logic dm_access_i,
	input wire logic [13:0] dm_addr_i,
	input wire logic [rbo_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [rbo_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [rbo_pkg::DATA_W-1:0] reg_rdata_o,
	output logic cycle_en_o,
	output logic cycle_clock_output_o,
	output logic pll_locked_o,
	output logic stack_empty_force_o,
	output logic irq_mask_all_o,
	output logic [rbo_pkg::MST_W-1:0] mode_status_register_o,
	output logic general_flag_two_o,
	output logic host_mode_o,
	output logic byte_dma_start_o,
	output logic [rbo_pkg::BOOT_CNT_W-1:0] byte_dma_count_o,
	output logic exec_run_o,
	output logic fetch_external_o,
	output logic [13:0] fetch_addr_o,
	output logic host_port_acknowledge_o,
	output logic host_port_acknowledge_oe_n_o,
	output logic [13:0] ext_addr_o,
	output logic ext_pm_sel_o,
	output logic ext_dm_sel_o,
	output logic dm_busy_o,
	output logic dm_done_o
);
	import rbo_pkg::*;

	localparam int LOCK_W = $clog2(LOCK_COUNT + 1);
	localparam logic [LOCK_W-1:0] LOCK_END = LOCK_W'(LOCK_COUNT);
	localparam int PIN_W = 6;

	// True when an address falls in an overlay window
	function automatic logic in_overlay(input logic [13:0] a);
		in_overlay = a[OVL_BANK_BIT];
	endfunction

	// External address for a given overlay and host/full mode
	function automatic logic [13:0] ovl_addr(input logic [1:0] sel,
			input logic [13:0] a, input logic host);
		logic [13:0] r;
		r = {(sel == OVL_EXT2), a[12:0]};
		if (host) begin
			r = {13'h0000, a[0]};
		end
		ovl_addr = r;
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [PIN_W-1:0] pin_s1_q;
	logic [PIN_W-1:0] pin_s2_q;
	logic [PIN_W-1:0] pin_s3_q;
	logic [PIN_W-1:0] pin_q;
	logic clock_input_prev_q;
	logic mrst_prev_q;
	logic mrst;
	logic clock_input_f;

	// Three stages; a change is taken once stages two and three agree
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			pin_q <= '0;
		end else begin
			pin_s1_q <= {clock_input_i, master_reset_n_i, mode_pins_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
		end
	end

	assign clock_input_f = pin_q[5];
	assign mrst = ~pin_q[4];

	// ---------------------------------------------------------------
	// Processor cycle generator
	// ---------------------------------------------------------------
	logic cyc_en_q;
	logic cyc_out_q;
	logic [LOCK_W-1:0] lock_cnt_q;
	logic lock_q;
	logic [CTL_W-1:0] ctl_q;

	// Only the power-on reset clears this; master reset leaves it running
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clock_input_prev_q <= 1'b0;
			cyc_en_q <= 1'b0;
		end else begin
			clock_input_prev_q <= clock_input_f;
			cyc_en_q <= clock_input_f ^ clock_input_prev_q;
		end
	end

	// Cycle clock output, gated by the disable bit
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cyc_out_q <= 1'b0;
		end else begin
			cyc_out_q <= (clock_input_f ^ clock_input_prev_q) & ~ctl_q[CTL_CLOCK_OUTPUT_DISABLE];
		end
	end

	// Lock counter; software sees it, the boot waits on it
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_cnt_q <= '0;
			lock_q <= 1'b0;
		end else if (!lock_q && clock_input_f && !clock_input_prev_q) begin
			lock_cnt_q <= lock_cnt_q + 1'b1;
			lock_q <= (lock_cnt_q + 1'b1) >= LOCK_END;
		end
	end

	// ---------------------------------------------------------------
	// Master reset and mode latch
	// ---------------------------------------------------------------
	logic [3:0] mode_q;
	logic mrst_q;
	logic flag2_q;
	logic host;
	logic release_p;

	assign release_p = mrst_prev_q & ~mrst;
	assign host = mode_q[MODE_C];

	// Track pins during reset, freeze at release so flag use is harmless
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= '0;
			mrst_prev_q <= 1'b1;
			mrst_q <= 1'b1;
		end else begin
			mrst_prev_q <= mrst;
			mrst_q <= mrst;
			if (mrst) begin
				mode_q <= pin_q[3:0];
			end
		end
	end

	// Shared pin is flag two once out of reset
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag2_q <= 1'b0;
		end else begin
			flag2_q <= mrst ? 1'b0 : pin_q[MODE_C];
		end
	end

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	logic [MST_W-1:0] mst_q;
	logic [DATA_W-1:0] rdata_q;
	rbo_boot_t st_q;

	// Control register written by software
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_q <= CTL_RESET;
		end else if (reg_wr_i && reg_addr_i == OFS_CONTROL) begin
			ctl_q <= reg_wdata_i[CTL_W-1:0];
		end
	end

	// Mode status; master reset wins over a write
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mst_q <= MST_RESET;
		end else if (mrst) begin
			mst_q <= MST_RESET;
		end else if (reg_wr_i && reg_addr_i == OFS_MODE_STATUS) begin
			mst_q <= reg_wdata_i[MST_W-1:0];
		end
	end

	// Read data valid one cycle after the strobe only
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= '0;
			if (reg_rd_i) begin
				case (reg_addr_i)
					OFS_CONTROL: rdata_q <= {{(DATA_W-CTL_W){1'b0}}, ctl_q};
					OFS_MODE_STATUS: rdata_q <= {{(DATA_W-MST_W){1'b0}}, mst_q};
					OFS_BOOT_STATUS: begin
						rdata_q <= '0;
						rdata_q[BST_MODE_LO +: 4] <= mode_q;
						rdata_q[BST_HOST] <= host;
						rdata_q[BST_RUN] <= (st_q == RBO_ST_RUN);
						rdata_q[BST_EXT] <= fetch_external_o;
						rdata_q[BST_LOCK] <= lock_q;
					end
					default: rdata_q <= '0;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Boot sequencer
	// ---------------------------------------------------------------
	logic [BOOT_CNT_W-1:0] boot_cnt_q;
	logic dma_start_q;
	logic run_q;
	logic ext_q;

	// Pick the boot path from the latched strap
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= RBO_ST_RESET;
			boot_cnt_q <= '0;
			dma_start_q <= 1'b0;
			run_q <= 1'b0;
			ext_q <= 1'b0;
		end else if (mrst) begin
			st_q <= RBO_ST_RESET;
			boot_cnt_q <= '0;
			dma_start_q <= 1'b0;
			run_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			dma_start_q <= 1'b0;
			case (st_q)
				RBO_ST_RESET, RBO_ST_BUSREQ: begin
					if (bus_request_i || !lock_q) begin
						st_q <= RBO_ST_BUSREQ;
					end else if (mode_q[2:0] == MODE_FULL_BYTE ||
							mode_q[2:0] == MODE_HOST_BYTE) begin
						st_q <= RBO_ST_BYTE_BOOT;
						dma_start_q <= 1'b1;
					end else if (mode_q[2:0] == MODE_HOST_PORT) begin
						st_q <= RBO_ST_HOST_BOOT;
					end else begin
						st_q <= RBO_ST_RUN;
						run_q <= 1'b1;
						// External start only in full mode
						ext_q <= (mode_q[2:0] == MODE_FULL_NOBOOT);
					end
				end
				RBO_ST_BYTE_BOOT: begin
					if (byte_dma_word_done_i) begin
						boot_cnt_q <= boot_cnt_q + 1'b1;
						if (boot_cnt_q == BOOT_CNT_W'(BOOT_WORDS - 1)) begin
							st_q <= RBO_ST_RUN;
							run_q <= 1'b1;
						end
					end
				end
				RBO_ST_HOST_BOOT: begin
					if (host_pm0_write_i) begin
						st_q <= RBO_ST_RUN;
						run_q <= 1'b1;
					end
				end
				RBO_ST_RUN: run_q <= 1'b1;
				default: st_q <= RBO_ST_RESET;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Host acknowledge pin
	// ---------------------------------------------------------------
	logic ack_q;
	logic ack_oe_n_q;

	// With D set, open drain drives only the high level and pull-down gives the low; with D clear, both levels are driven
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			ack_oe_n_q <= 1'b1;
		end else begin
			ack_q <= host_ack_i;
			if (!host) begin
				ack_oe_n_q <= 1'b1;
			end else if (!mode_q[MODE_D]) begin
				ack_oe_n_q <= 1'b0;
			end else begin
				ack_oe_n_q <= ~host_ack_i;
			end
		end
	end

	// ---------------------------------------------------------------
	// Overlay decode and data wait states
	// ---------------------------------------------------------------
	logic [13:0] ext_addr_q;
	logic pm_sel_q;
	logic dm_sel_q;
	logic [WCNT_W-1:0] wcnt_q;
	logic busy_q;
	logic done_q;
	logic [1:0] pm_ovl;
	logic [1:0] dm_ovl;
	logic pm_ext;
	logic dm_ext;
	logic [WAIT_W-1:0] data_wait_states;
	logic [WCNT_W-1:0] wload;

	assign pm_ovl = ctl_q[CTL_PMOVL_LO +: 2];
	assign dm_ovl = ctl_q[CTL_DMOVL_LO +: 2];
	assign data_wait_states = ctl_q[CTL_DATA_WAIT_STATES_LO +: WAIT_W];
	// Overlay value 3 is unmapped and treated as internal
	assign pm_ext = in_overlay(pm_addr_i) &&
		(pm_ovl == OVL_EXT1 || pm_ovl == OVL_EXT2);
	assign dm_ext = in_overlay(dm_addr_i) &&
		(dm_ovl == OVL_EXT1 || dm_ovl == OVL_EXT2);
	// Wait mode doubles the field and adds one, up to fifteen
	assign wload = ctl_q[CTL_WMODE] ? {data_wait_states, 1'b1} : {1'b0, data_wait_states};

	// External address; data access takes the bus over program access
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_addr_q <= '0;
			pm_sel_q <= 1'b0;
			dm_sel_q <= 1'b0;
		end else begin
			pm_sel_q <= pm_access_i && pm_ext && !(dm_access_i && dm_ext);
			dm_sel_q <= dm_access_i && dm_ext && !busy_q;
			if (dm_access_i && dm_ext && !busy_q) begin
				ext_addr_q <= ovl_addr(dm_ovl, dm_addr_i, host);
			end else if (pm_access_i && pm_ext) begin
				ext_addr_q <= ovl_addr(pm_ovl, pm_addr_i, host);
			end
		end
	end

	// Access timing; requests during a stretch are ignored
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wcnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (busy_q) begin
				if (wcnt_q == '0) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					wcnt_q <= wcnt_q - 1'b1;
				end
			end else if (dm_access_i && !dm_ext) begin
				done_q <= 1'b1;
			end else if (dm_access_i) begin
				busy_q <= 1'b1;
				wcnt_q <= wload;
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o = rdata_q;
	assign cycle_en_o = cyc_en_q;
	assign cycle_clock_output_o = cyc_out_q;
	assign pll_locked_o = lock_q;
	assign stack_empty_force_o = mrst_q;
	assign irq_mask_all_o = mrst_q;
	assign mode_status_register_o = mst_q;
	assign general_flag_two_o = flag2_q;
	assign host_mode_o = host;
	assign byte_dma_start_o = dma_start_q;
	assign byte_dma_count_o = BOOT_CNT_W'(BOOT_WORDS);
	assign exec_run_o = run_q;
	assign fetch_external_o = ext_q;
	assign fetch_addr_o = START_ADDR;
	assign host_port_acknowledge_o = ack_q;
	assign host_port_acknowledge_oe_n_o = ack_oe_n_q;
	assign ext_addr_o = ext_addr_q;
	assign ext_pm_sel_o = pm_sel_q;
	assign ext_dm_sel_o = dm_sel_q;
	assign dm_busy_o = busy_q;
	assign dm_done_o = done_q;

endmodule // rbo_core

`default_nettype wire

/* design/rbo_core_pad.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* design/rbo_pkg.sv */
package rbo_pkg;

	// ---------------------------------------------------------------
	// Register map, 16-bit data, word aligned offsets
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BOOT_STATUS = 8'h08;

	// Control register fields
	localparam int CTL_CLOCK_OUTPUT_DISABLE = 0;
	localparam int CTL_PMOVL_LO = 1;
	localparam int CTL_DMOVL_LO = 3;
	localparam int CTL_DATA_WAIT_STATES_LO = 5;
	localparam int CTL_WMODE = 8;
	localparam int CTL_W = 9;
	localparam logic [CTL_W-1:0] CTL_RESET = 9'h000;

	// Mode status register, cleared by every master reset
	localparam int MST_W = 7;
	localparam logic [MST_W-1:0] MST_RESET = 7'h00;

	// Boot status fields
	localparam int BST_MODE_LO = 0;
	localparam int BST_HOST = 4;
	localparam int BST_RUN = 5;
	localparam int BST_EXT = 6;
	localparam int BST_LOCK = 7;

	// ---------------------------------------------------------------
	// Mode pins C,B,A and boot behaviour
	// ---------------------------------------------------------------
	localparam logic [2:0] MODE_FULL_BYTE = 3'h0;
	localparam logic [2:0] MODE_FULL_NOBOOT = 3'h2;
	localparam logic [2:0] MODE_HOST_BYTE = 3'h4;
	localparam logic [2:0] MODE_HOST_PORT = 3'h5;
	localparam int MODE_C = 2;
	localparam int MODE_D = 3;
	localparam int BOOT_WORDS = 32;
	localparam int BOOT_CNT_W = 6;
	localparam logic [13:0] START_ADDR = 14'h0000;

	// ---------------------------------------------------------------
	// Overlay decode
	// ---------------------------------------------------------------
	localparam logic [1:0] OVL_INTERNAL = 2'h0;
	localparam logic [1:0] OVL_EXT1 = 2'h1;
	localparam logic [1:0] OVL_EXT2 = 2'h2;
	localparam int OVL_BANK_BIT = 13;
	localparam int WAIT_W = 3;
	localparam int WCNT_W = 4;

	// Lock time of the internal loop in clock input cycles
	localparam int LOCK_CYCLES = 2000;

	typedef enum {
		RBO_ST_RESET,
		RBO_ST_BUSREQ,
		RBO_ST_BYTE_BOOT,
		RBO_ST_HOST_BOOT,
		RBO_ST_RUN
	} rbo_boot_t;

endpackage

/* tb/rbo_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rbo_board_model (
	input wire logic core_clk_i,
	input wire logic mrst_req_i,
	input wire logic [3:0] strap_i,
	input wire logic flag_i,
	output logic clock_input_o,
	output logic master_reset_n_o,
	output logic [3:0] mode_pins_o
);
	logic [1:0] div_q = 2'h0;

	// Clock source, never halted, eight core cycles a period
	initial clock_input_o = 1'b0;
	always @(posedge core_clk_i) begin
		div_q <= div_q + 2'h1;
		if (div_q == 2'h3) begin
			clock_input_o <= ~clock_input_o;
		end
	end

	// Reset low as long as asked; bench holds it past lock time
	assign master_reset_n_o = ~mrst_req_i;
	// Strap driver on C lets go at release, flag user takes over
	assign mode_pins_o = {strap_i[3],
		master_reset_n_o ? flag_i : strap_i[2], strap_i[1:0]};
endmodule // rbo_board_model
`default_nettype wire

/* tb/rbo_core_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module rbo_core_chk
	import rbo_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clock_input_i,
	input wire logic master_reset_n_i,
	input wire logic [3:0] mode_pins_i,
	input wire logic byte_dma_word_done_i,
	input wire logic pm_access_i,
	input wire logic [13:0] pm_addr_i,
	input wire logic dm_access_i,
	input wire logic [13:0] dm_addr_i,
	input wire logic [rbo_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [rbo_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic cycle_en_o,
	input wire logic cycle_clock_output_o,
	input wire logic stack_empty_force_o,
	input wire logic irq_mask_all_o,
	input wire logic [rbo_pkg::MST_W-1:0] mode_status_register_o,
	input wire logic host_mode_o,
	input wire logic byte_dma_start_o,
	input wire logic exec_run_o,
	input wire logic host_port_acknowledge_o,
	input wire logic host_port_acknowledge_oe_n_o,
	input wire logic [13:0] ext_addr_o,
	input wire logic ext_pm_sel_o,
	input wire logic ext_dm_sel_o,
	input wire logic dm_busy_o,
	input wire logic dm_done_o
);
	import rbo_pkg::*;

	logic [CTL_W-1:0] ctl_q;
	logic ext_q, boot_q;
	logic [3:0] wexp_q;
	logic [4:0] bcnt_q;
	logic [5:0] wcnt_q;
	logic dm_take, dm_ext, pm_ext;
	logic [13:0] dm_ea, pm_ea;

	// -------------------------------
	// Shadow state
	// -------------------------------
	// Control copy, so overlay checks need no hierarchy peeking
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_q <= CTL_RESET;
		end else if (reg_wr_i && reg_addr_i == OFS_CONTROL) begin
			ctl_q <= reg_wdata_i[CTL_W-1:0];
		end
	end

	// Overlay values 1 and 2 go outside; host mode keeps only A0
	assign dm_take = dm_access_i && !dm_busy_o;
	assign dm_ext = dm_addr_i[13] && ^ctl_q[4:3];
	assign pm_ext = pm_access_i && !dm_access_i && !dm_busy_o &&
		!host_mode_o && pm_addr_i[13] && ^ctl_q[2:1];
	assign dm_ea = host_mode_o ? {13'h0000, dm_addr_i[0]} :
		{ctl_q[4], dm_addr_i[12:0]};
	assign pm_ea = {ctl_q[2], pm_addr_i[12:0]};

	// Wait stretch length expected and busy cycles seen
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_q <= 1'b0;
			wexp_q <= 4'h0;
			bcnt_q <= 5'h00;
		end else begin
			bcnt_q <= dm_busy_o ? bcnt_q + 5'h01 : 5'h00;
			if (dm_take && dm_ext) begin
				ext_q <= 1'b1;
				wexp_q <= ctl_q[8] ? {ctl_q[7:5], 1'b1} : {1'b0, ctl_q[7:5]};
			end else if (dm_done_o) begin
				ext_q <= 1'b0;
			end
		end
	end

	// Boot words counted from the start pulse
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boot_q <= 1'b0;
			wcnt_q <= 6'h00;
		end else if (stack_empty_force_o || byte_dma_start_o) begin
			boot_q <= byte_dma_start_o;
			wcnt_q <= 6'h00;
		end else if (boot_q && byte_dma_word_done_i) begin
			wcnt_q <= wcnt_q + 6'h01;
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_cycle_edge: assert property ($changed(clock_input_i)
		|-> ##[2:8] cycle_en_o) else $error("cycle pulse missing");
	chk_cycle_clock_output_gate: assert property (cycle_clock_output_o
		|-> cycle_en_o) else $error("clock output off cycle");
	chk_mrst_mask: assert property ($fell(master_reset_n_i)
		|-> ##[2:6] stack_empty_force_o && irq_mask_all_o)
		else $error("master reset not applied");
	chk_mode_status_register_clear: assert property (stack_empty_force_o &&
		$past(stack_empty_force_o) |-> mode_status_register_o == MST_RESET)
		else $error("mode status not cleared");
	chk_boot_words: assert property ($rose(exec_run_o) && boot_q
		|-> wcnt_q == 6'h20) else $error("run before all words");
	chk_dm_internal: assert property (dm_take && !dm_ext
		|=> dm_done_o && !ext_dm_sel_o) else $error("internal not 1 cycle");
	chk_dm_overlay: assert property (dm_take && dm_ext
		|=> ext_dm_sel_o && ext_addr_o == $past(dm_ea))
		else $error("data overlay address wrong");
	chk_dm_stretch: assert property (dm_done_o && ext_q
		|-> bcnt_q == {1'b0, wexp_q} + 5'h01) else $error("wait count wrong");
	chk_pm_overlay: assert property (pm_ext
		|=> ext_pm_sel_o && ext_addr_o == $past(pm_ea))
		else $error("program overlay address wrong");
	chk_ack_drain: assert property (host_mode_o && mode_pins_i[3] &&
		master_reset_n_i && !stack_empty_force_o |->
		host_port_acknowledge_oe_n_o == !host_port_acknowledge_o)
		else $error("open drain ack wrong");

	// Main scenarios reached
	cov_run: cover property ($rose(exec_run_o));
	cov_ext_dm: cover property (dm_done_o && ext_q);
	cov_ext_pm: cover property (ext_pm_sel_o);
endmodule // rbo_core_chk

bind rbo_core rbo_core_chk u_rbo_core_chk (.*);
`default_nettype wire

/* tb/reset_boot_mode_overlay_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
num_errors++; $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module reset_boot_mode_overlay_tb_top;
	import rbo_pkg::*;

	logic core_clk_i, rst_n_i, clock_input_i, master_reset_n_i;
	logic bus_request_i, byte_dma_word_done_i, host_pm0_write_i;
	logic host_ack_i, pm_access_i, dm_access_i, reg_wr_i, reg_rd_i;
	logic [3:0] mode_pins_i, strap;
	logic [13:0] pm_addr_i, dm_addr_i, fetch_addr_o, ext_addr_o;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
	logic cycle_en_o, cycle_clock_output_o, pll_locked_o;
	logic stack_empty_force_o, irq_mask_all_o, general_flag_two_o;
	logic host_mode_o, byte_dma_start_o, exec_run_o, fetch_external_o;
	logic host_port_acknowledge_o, host_port_acknowledge_oe_n_o;
	logic ext_pm_sel_o, ext_dm_sel_o, dm_busy_o, dm_done_o, mrq, flag_i;
	logic [MST_W-1:0] mode_status_register_o;
	logic [BOOT_CNT_W-1:0] byte_dma_count_o;
	int num_errors, n_compared;

	// Short lock count keeps the run brief
	rbo_core #(.LOCK_COUNT(8)) u_rbo_core (.*);
	rbo_board_model u_rbo_board_model (.core_clk_i(core_clk_i),
		.mrst_req_i(mrq), .strap_i(strap), .flag_i(flag_i),
		.clock_input_o(clock_input_i), .master_reset_n_o(master_reset_n_i),
		.mode_pins_o(mode_pins_i));

	always #5 core_clk_i = ~core_clk_i;

	task automatic tk(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	// -------------------------------
	// Bus cycles
	// -------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		tk(1);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		tk(1);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		tk(1);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		tk(1);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	// Board reset with straps; cycle pulses must go on meanwhile
	task automatic mrst(input logic [3:0] m);
		int p;
		p = 0;
		strap <= m;
		mrq <= 1'b1;
		repeat (80) begin
			tk(1);
			#1 p += cycle_en_o;
		end
		`CHK("pulses_in_reset", 1, p > 0)
		mrq <= 1'b0;
		tk(8);
	endtask

	// One access; pm ignores busy, dm counts its stretch
	task automatic acc(input logic pm, input logic [13:0] a, ea,
		input int nb);
		int b;
		b = 0;
		tk(1);
		dm_addr_i <= a;
		pm_addr_i <= a;
		dm_access_i <= !pm;
		pm_access_i <= pm;
		tk(1);
		dm_access_i <= 1'b0;
		pm_access_i <= 1'b0;
		#1 if (nb > 0) `CHK("ext_addr", ea, ext_addr_o)
		for (int i = 0; !pm && i < 40 && dm_done_o !== 1'b1; i++) begin
			b += dm_busy_o;
			tk(1);
			#1;
		end
		`CHK("busy_len", nb, pm ? 32'(ext_pm_sel_o) : b)
	endtask

	// -------------------------------
	// Scenarios
	// -------------------------------
	task automatic t_byte();
		bus_request_i <= 1'b1;
		mrst(4'h0);
		tk(30);
		#1 `CHK("busreq_hold", 1'b0, exec_run_o)
		`CHK("locked", 1'b1, pll_locked_o)
		bus_request_i <= 1'b0;
		for (int i = 0; i < 200 && byte_dma_start_o !== 1'b1; i++) begin
			tk(1);
			#1;
		end
		`CHK("dma_start", 1'b1, byte_dma_start_o)
		`CHK("dma_count", 6'h20, byte_dma_count_o)
		for (int i = 0; i < 32; i++) begin
			tk(1);
			#1 if (i == 31) `CHK("early_run", 1'b0, exec_run_o)
			byte_dma_word_done_i <= 1'b1;
		end
		tk(1);
		byte_dma_word_done_i <= 1'b0;
		tk(1);
		#1 `CHK("run", 1'b1, exec_run_o)
		`CHK("fetch", 15'h0000, {fetch_external_o, fetch_addr_o})
	endtask

	// No boot, full mode; registers and overlays
	task automatic t_full();
		logic [15:0] d;
		int n;
		mrst(4'h2);
		tk(5);
		#1 `CHK("run_ext", 2'h3, {exec_run_o, fetch_external_o})
		rd(OFS_BOOT_STATUS, d);
		`CHK("boot_stat", 16'h00E2, d)
		for (int k = 0; k < 2; k++) begin
			wr(OFS_CONTROL, k ? 16'h0000 : 16'h0001);
			n = 0;
			repeat (40) begin
				tk(1);
				#1 n += cycle_clock_output_o;
			end
			`CHK("cycle_clock_output", k, n > 0)
		end
		rd(8'h0C, d);
		`CHK("unmapped", 16'h0000, d)
		wr(OFS_MODE_STATUS, 16'h007F);
		rd(OFS_MODE_STATUS, d);
		`CHK("mode_status_register", 16'h007F, d)
		`CHK("mode_status_register_port", 7'h7F, mode_status_register_o)
		// Reserved bits above the wait mode bit stay zero
		wr(OFS_CONTROL, 16'h004C);
		acc(1'b0, 14'h3ABC, 14'h1ABC, 3);
		acc(1'b0, 14'h0010, 14'h0000, 0);
		acc(1'b1, 14'h2123, 14'h2123, 1);
		wr(OFS_CONTROL, 16'h0112);
		acc(1'b0, 14'h2005, 14'h2005, 2);
		acc(1'b1, 14'h3FFF, 14'h1FFF, 1);
	endtask

	// Host port boot, open drain ack, flag use of C
	task automatic t_host();
		logic [15:0] d;
		flag_i <= 1'b0;
		mrst(4'hD);
		tk(30);
		#1 `CHK("host_wait", 3'h2, {exec_run_o, host_mode_o,
			general_flag_two_o})
		flag_i <= 1'b1;
		host_ack_i <= 1'b1;
		tk(6);
		#1 `CHK("flag", 3'h6, {host_mode_o, general_flag_two_o,
			host_port_acknowledge_oe_n_o})
		host_ack_i <= 1'b0;
		host_pm0_write_i <= 1'b1;
		tk(1);
		host_pm0_write_i <= 1'b0;
		tk(3);
		#1 `CHK("host_run", 3'h5, {exec_run_o, fetch_external_o,
			host_port_acknowledge_oe_n_o})
		wr(OFS_CONTROL, 16'h0008);
		acc(1'b0, 14'h2005, 14'h0001, 1);
		mrst(4'h4);
		tk(10);
		#1 `CHK("ack_drive", 1'b0, host_port_acknowledge_oe_n_o)
		rd(OFS_MODE_STATUS, d);
		`CHK("mode_status_register_clr", 16'h0000, d)
	endtask

	task automatic close_out();
		if (num_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence, power-on reset for 10 cycles first
	initial begin
		{core_clk_i, rst_n_i, bus_request_i, byte_dma_word_done_i} = 4'h0;
		{host_pm0_write_i, host_ack_i, pm_access_i, dm_access_i} = 4'h0;
		{reg_wr_i, reg_rd_i, flag_i, strap, pm_addr_i, dm_addr_i} = '0;
		{reg_addr_i, reg_wdata_i} = '0;
		mrq = 1'b1;
		num_errors = 0;
		n_compared = 0;
		tk(10);
		rst_n_i <= 1'b1;
		t_byte();
		t_full();
		t_host();
		close_out();
	end

	// Hang guard, well past the expected run of several hundred cycles
	initial begin
		#200000;
		num_errors++;
		close_out();
	end
endmodule // reset_boot_mode_overlay_tb_top
`default_nettype wire
